// File: crf_pkg.sv
// Constants, register map and carrier types for the core register file
package crf_pkg;

    // ************************************************************
    // Widths and counts
    // ************************************************************
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned ADDR20_W  = 20;
    localparam int unsigned FLAGS_W   = 11;
    localparam int unsigned BANK_REGS = 7;
    localparam int unsigned BANKS     = 2;
    localparam int unsigned BUS_AW    = 8;
    localparam int unsigned BUS_DW    = 32;

    // ************************************************************
    // Register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] OFF_BANKED_BASE = 8'h00;
    localparam logic [7:0] OFF_STRIDE      = 8'h04;
    localparam logic [7:0] OFF_VECTOR_BASE = 8'h1c;
    localparam logic [7:0] OFF_INSTR_PTR   = 8'h20;
    localparam logic [7:0] OFF_USER_SP     = 8'h24;
    localparam logic [7:0] OFF_INTR_SP     = 8'h28;
    localparam logic [7:0] OFF_STATIC_BASE = 8'h2c;
    localparam logic [7:0] OFF_FLAGS       = 8'h30;
    localparam logic [7:0] OFF_D0_HIGH     = 8'h34;
    localparam logic [7:0] OFF_D0_LOW      = 8'h38;
    localparam logic [7:0] OFF_D1_HIGH     = 8'h3c;
    localparam logic [7:0] OFF_D1_LOW      = 8'h40;
    localparam logic [7:0] OFF_PAIR_LO     = 8'h44;
    localparam logic [7:0] OFF_PAIR_HI     = 8'h48;
    localparam logic [7:0] OFF_ADDR_LONG   = 8'h4c;
    localparam logic [7:0] OFF_ACTIVE_SP   = 8'h50;

    // Banked register indices within a bank
    localparam int unsigned IDX_D0 = 0;
    localparam int unsigned IDX_D1 = 1;
    localparam int unsigned IDX_D2 = 2;
    localparam int unsigned IDX_D3 = 3;
    localparam int unsigned IDX_A0 = 4;
    localparam int unsigned IDX_A1 = 5;

    // ************************************************************
    // Status flag bit positions
    // ************************************************************
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_D = 1;
    localparam int unsigned FLG_Z = 2;
    localparam int unsigned FLG_S = 3;
    localparam int unsigned FLG_B = 4;
    localparam int unsigned FLG_O = 5;
    localparam int unsigned FLG_I = 6;
    localparam int unsigned FLG_U = 7;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [19:0] RST_ADDR20 = 20'h00000;
    localparam logic [10:0] RST_FLAGS  = 11'h000;
    localparam logic [31:0] RD_IDLE    = 32'h0000_0000;

    // ALU result handed over for flag update
    typedef struct packed {
        logic        valid;
        logic        is_long;
        logic [31:0] result;
        logic        carry;
        logic        overflow;
    } crf_alu_res_t;

endpackage

// File: crf_core_regs.sv
// Core register file: banked data/address registers, pointers and status flags
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module crf_core_regs (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Software register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_we,
    input  wire logic                 reg_re,
    output logic      [31:0]          reg_rdata_q,
    // ALU result for flag update
    input  wire crf_pkg::crf_alu_res_t alu_res,
    // Maskable interrupt request and acceptance
    input  wire logic                 irq_req,
    output logic                      irq_accept_q,
    // Register state towards the core
    output logic      [10:0]          flags_q,
    output logic      [19:0]          instr_ptr_q,
    output logic      [19:0]          vector_base_q,
    output logic      [15:0]          static_base_q
);

    // ************************************************************
    // Storage
    // ************************************************************
    // two banks of seven
    logic [15:0] bank_q [crf_pkg::BANKS][crf_pkg::BANK_REGS];
    logic [15:0] user_sp_q;
    logic [15:0] intr_sp_q;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic bank_sel   = flags_q[crf_pkg::FLG_B];
    wire logic stack_sel  = flags_q[crf_pkg::FLG_U];
    wire logic hit_d0h    = reg_addr == crf_pkg::OFF_D0_HIGH;
    wire logic hit_d0l    = reg_addr == crf_pkg::OFF_D0_LOW;
    wire logic hit_d1h    = reg_addr == crf_pkg::OFF_D1_HIGH;
    wire logic hit_d1l    = reg_addr == crf_pkg::OFF_D1_LOW;
    wire logic hit_plo    = reg_addr == crf_pkg::OFF_PAIR_LO;
    wire logic hit_phi    = reg_addr == crf_pkg::OFF_PAIR_HI;
    wire logic hit_along  = reg_addr == crf_pkg::OFF_ADDR_LONG;
    wire logic hit_vbase  = reg_addr == crf_pkg::OFF_VECTOR_BASE;
    wire logic hit_ip     = reg_addr == crf_pkg::OFF_INSTR_PTR;
    wire logic hit_usp    = reg_addr == crf_pkg::OFF_USER_SP;
    wire logic hit_isp    = reg_addr == crf_pkg::OFF_INTR_SP;
    wire logic hit_sb     = reg_addr == crf_pkg::OFF_STATIC_BASE;
    wire logic hit_flags  = reg_addr == crf_pkg::OFF_FLAGS;
    wire logic hit_asp    = reg_addr == crf_pkg::OFF_ACTIVE_SP;

    // Per-entry write lanes of the active bank
    wire logic [crf_pkg::BANK_REGS-1:0] wr_hi;
    wire logic [crf_pkg::BANK_REGS-1:0] wr_lo;
    wire logic [15:0]                   wr_val [crf_pkg::BANK_REGS];
    wire logic [crf_pkg::BANK_REGS-1:0] hit_word;

    genvar j;
    generate
        for (j = 0; j < crf_pkg::BANK_REGS; j++) begin : g_lane
            wire logic long_lo = (j == crf_pkg::IDX_D0 && hit_plo)
                              || (j == crf_pkg::IDX_D1 && hit_phi)
                              || (j == crf_pkg::IDX_A0 && hit_along);
            wire logic long_hi = (j == crf_pkg::IDX_D2 && hit_plo)
                              || (j == crf_pkg::IDX_D3 && hit_phi)
                              || (j == crf_pkg::IDX_A1 && hit_along);
            // byte halves of first two words
            wire logic byte_h  = (j == crf_pkg::IDX_D0 && hit_d0h)
                              || (j == crf_pkg::IDX_D1 && hit_d1h);
            wire logic byte_l  = (j == crf_pkg::IDX_D0 && hit_d0l)
                              || (j == crf_pkg::IDX_D1 && hit_d1l);
            assign hit_word[j] = reg_addr == 8'(crf_pkg::OFF_BANKED_BASE
                                 + crf_pkg::OFF_STRIDE * j);
            assign wr_hi[j] = reg_we && (hit_word[j] || long_lo || long_hi || byte_h);
            assign wr_lo[j] = reg_we && (hit_word[j] || long_lo || long_hi || byte_l);
            assign wr_val[j] = long_hi ? reg_wdata[31:16]
                             : byte_h  ? {reg_wdata[7:0], 8'h00}
                             : reg_wdata[15:0];
        end
    endgenerate

    // ************************************************************
    // Banked registers
    // ************************************************************
    // writes land in the selected bank only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int b = 0; b < crf_pkg::BANKS; b++) begin
                for (int r = 0; r < crf_pkg::BANK_REGS; r++) begin
                    bank_q[b][r] <= crf_pkg::RST_WORD;
                end
            end
        end else begin
            for (int r = 0; r < crf_pkg::BANK_REGS; r++) begin
                if (wr_hi[r]) begin
                    bank_q[bank_sel][r][15:8] <= wr_val[r][15:8];
                end
                if (wr_lo[r]) begin
                    bank_q[bank_sel][r][7:0] <= wr_val[r][7:0];
                end
            end
        end
    end

    // ************************************************************
    // Unbanked registers
    // ************************************************************
    // active pointer alias follows stack flag
    wire logic wr_usp = reg_we && (hit_usp || (hit_asp && !stack_sel));
    wire logic wr_isp = reg_we && (hit_isp || (hit_asp && stack_sel));

    // 20-bit vector base; 20-bit pointer; static base
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            user_sp_q     <= crf_pkg::RST_WORD;
            intr_sp_q     <= crf_pkg::RST_WORD;
            vector_base_q <= crf_pkg::RST_ADDR20;
            instr_ptr_q   <= crf_pkg::RST_ADDR20;
            static_base_q <= crf_pkg::RST_WORD;
        end else begin
            if (wr_usp) begin
                user_sp_q <= reg_wdata[15:0];
            end
            if (wr_isp) begin
                intr_sp_q <= reg_wdata[15:0];
            end
            if (reg_we && hit_vbase) begin
                vector_base_q <= reg_wdata[19:0];
            end
            if (reg_we && hit_ip) begin
                instr_ptr_q <= reg_wdata[19:0];
            end
            if (reg_we && hit_sb) begin
                static_base_q <= reg_wdata[15:0];
            end
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    // zero test at the operand width
    wire logic alu_zero = alu_res.is_long ? (alu_res.result == 32'h0000_0000)
                                          : (alu_res.result[15:0] == 16'h0000);
    // sign is the top bit at the operand width
    wire logic alu_sign = alu_res.is_long ? alu_res.result[31] : alu_res.result[15];
    // only an enabled core accepts a maskable request
    wire logic accept   = irq_req && flags_q[crf_pkg::FLG_I];

    logic [10:0] flags_d;
    // ALU update beats a software write; acceptance beats both for the enable
    always_comb begin
        flags_d = flags_q;
        // whole 11-bit register writable; debug bit left to software
        if (reg_we && hit_flags) begin
            flags_d = reg_wdata[10:0];
        end
        if (alu_res.valid) begin
            flags_d[crf_pkg::FLG_C] = alu_res.carry;
            flags_d[crf_pkg::FLG_Z] = alu_zero;
            flags_d[crf_pkg::FLG_S] = alu_sign;
            flags_d[crf_pkg::FLG_O] = alu_res.overflow;
        end
        if (accept) begin
            flags_d[crf_pkg::FLG_I] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags_q      <= crf_pkg::RST_FLAGS;
            irq_accept_q <= 1'b0;
        end else begin
            flags_q      <= flags_d;
            irq_accept_q <= accept;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    wire logic [15:0] sp_active = stack_sel ? intr_sp_q : user_sp_q;
    wire logic [15:0] d0 = bank_q[bank_sel][crf_pkg::IDX_D0];
    wire logic [15:0] d1 = bank_q[bank_sel][crf_pkg::IDX_D1];
    wire logic [15:0] d2 = bank_q[bank_sel][crf_pkg::IDX_D2];
    wire logic [15:0] d3 = bank_q[bank_sel][crf_pkg::IDX_D3];
    wire logic [15:0] a0 = bank_q[bank_sel][crf_pkg::IDX_A0];
    wire logic [15:0] a1 = bank_q[bank_sel][crf_pkg::IDX_A1];
    wire logic [15:0] fb = bank_q[bank_sel][6];

    // Unmapped offsets read as zero
    wire logic [31:0] rd_mux =
          hit_word[0] ? {16'h0000, d0}
        : hit_word[1] ? {16'h0000, d1}
        : hit_word[2] ? {16'h0000, d2}
        : hit_word[3] ? {16'h0000, d3}
        : hit_word[4] ? {16'h0000, a0}
        : hit_word[5] ? {16'h0000, a1}
        // frame base of the active bank
        : hit_word[6] ? {16'h0000, fb}
        : hit_vbase   ? {12'h000, vector_base_q}
        : hit_ip      ? {12'h000, instr_ptr_q}
        : hit_usp     ? {16'h0000, user_sp_q}
        : hit_isp     ? {16'h0000, intr_sp_q}
        : hit_sb      ? {16'h0000, static_base_q}
        : hit_flags   ? {21'h000000, flags_q}
        : hit_d0h     ? {24'h000000, d0[15:8]}
        : hit_d0l     ? {24'h000000, d0[7:0]}
        : hit_d1h     ? {24'h000000, d1[15:8]}
        : hit_d1l     ? {24'h000000, d1[7:0]}
        : hit_plo     ? {d2, d0}
        : hit_phi     ? {d3, d1}
        : hit_along   ? {a1, a0}
        : hit_asp     ? {16'h0000, sp_active}
        : crf_pkg::RD_IDLE;

    // Data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= crf_pkg::RD_IDLE;
        end else begin
            reg_rdata_q <= reg_re ? rd_mux : crf_pkg::RD_IDLE;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_bank_read_sel: assert property (
        reg_re && hit_word[0] && bank_sel |=> reg_rdata_q[15:0] == $past(bank_q[1][0]))
        else $error("banked read ignored bank flag");

    a_byte_keep_high: assert property (
        reg_we && hit_d0l && !bank_sel
        |=> bank_q[0][0][15:8] == $past(bank_q[0][0][15:8])
            && bank_q[0][0][7:0] == $past(reg_wdata[7:0]))
        else $error("low byte write disturbed high byte");

    a_pair_long_write: assert property (
        reg_we && hit_plo && !bank_sel
        |=> bank_q[0][2] == $past(reg_wdata[31:16]) && bank_q[0][0] == $past(reg_wdata[15:0]))
        else $error("paired long write split wrong");

    a_stack_sel_read: assert property (
        reg_re && hit_asp && !stack_sel ##1 1'b1 |-> reg_rdata_q[15:0] == $past(user_sp_q))
        else $error("active stack pointer alias wrong");

    a_carry_capture: assert property (
        alu_res.valid && alu_res.carry |=> flags_q[crf_pkg::FLG_C])
        else $error("carry not captured");

    a_zero_flag_set: assert property (
        alu_res.valid && !alu_res.is_long && alu_res.result[15:0] == 16'h0000
        |=> flags_q[crf_pkg::FLG_Z])
        else $error("zero flag not set on zero result");

    a_sign_flag_set: assert property (
        alu_res.valid && alu_res.is_long && alu_res.result[31] |=> flags_q[crf_pkg::FLG_S])
        else $error("sign flag not set on negative result");

    a_overflow_flag: assert property (
        alu_res.valid |=> flags_q[crf_pkg::FLG_O] == $past(alu_res.overflow))
        else $error("overflow flag mismatch");

    a_accept_gated: assert property (
        !flags_q[crf_pkg::FLG_I] |=> !irq_accept_q)
        else $error("request accepted while masked");

    a_enable_cleared: assert property (
        irq_accept_q |-> !flags_q[crf_pkg::FLG_I] ##1 !irq_accept_q)
        else $error("enable flag not cleared on acceptance");

    a_read_one_cycle: assert property (
        !reg_re |=> reg_rdata_q == crf_pkg::RD_IDLE)
        else $error("read data outside its cycle");

endmodule

// File: test_cpu_register_file_flags.sv
// Self-checking bench for the core register file through its software, ALU-result and interrupt ports
`timescale 1ns/1ns
module test_cpu_register_file_flags;
    logic                  ref_clk = 1'b0;
    logic                  rst     = 1'b1;
    logic [7:0]            reg_addr = 8'h00;
    logic [31:0]           reg_wdata = 32'h0000_0000;
    logic                  reg_we = 1'b0;
    logic                  reg_re = 1'b0;
    logic [31:0]           reg_rdata_q;
    crf_pkg::crf_alu_res_t alu_res = '0;
    logic                  irq_req = 1'b0;
    logic                  irq_accept_q;
    logic [10:0]           flags_q;
    logic [19:0]           instr_ptr_q;
    logic [19:0]           vector_base_q;
    logic [15:0]           static_base_q;
    int                    fail_count = 0;
    int                    check_count = 0;
    logic [31:0]           rv;

    // Unbanked words, their read masks; upper bits must read back 0
    localparam logic [7:0]  U_OFF [5] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
    localparam logic [31:0] U_MSK [5] = '{32'h000f_ffff, 32'h000f_ffff, 32'h0000_ffff,
                                          32'h0000_ffff, 32'h0000_ffff};

    crf_core_regs dut_u (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_we        (reg_we),
        .reg_re        (reg_re),
        .reg_rdata_q   (reg_rdata_q),
        .alu_res       (alu_res),
        .irq_req       (irq_req),
        .irq_accept_q  (irq_accept_q),
        .flags_q       (flags_q),
        .instr_ptr_q   (instr_ptr_q),
        .vector_base_q (vector_base_q),
        .static_base_q (static_base_q)
    );

    always #4 ref_clk = ~ref_clk;

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we    <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_re   <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, rv);
        check($sformatf("read %h", a), rv, exp);
    endtask

    // Expected flags are worked out here from the result width
    task automatic alu(input logic lng, input logic [31:0] r, input logic c, input logic o);
        logic [31:0] w;
        w = lng ? r : {16'h0000, r[15:0]};
        @(posedge ref_clk);
        alu_res <= '{valid: 1'b1, is_long: lng, result: r, carry: c, overflow: o};
        @(posedge ref_clk);
        alu_res.valid <= 1'b0;
        #1;
        check("carry", 32'(flags_q[crf_pkg::FLG_C]), 32'(c));
        check("zero", 32'(flags_q[crf_pkg::FLG_Z]), 32'(w == 32'h0));
        check("sign", 32'(flags_q[crf_pkg::FLG_S]), 32'(lng ? r[31] : r[15]));
        check("overflow", 32'(flags_q[crf_pkg::FLG_O]), 32'(o));
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run is well under two thousand cycles
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        check("flags after reset", 32'(flags_q), 32'h0);
        check("accept after reset", 32'(irq_accept_q), 32'h0);
        $display("test reset done");

        // Seven banked registers, two copies selected by the bank flag
        for (int i = 0; i < 7; i++) wr(8'(4 * i), 32'hffff_1000 + i);
        wr(crf_pkg::OFF_FLAGS, 32'h0000_0010);
        check("bank flag", 32'(flags_q[crf_pkg::FLG_B]), 32'h1);
        for (int i = 0; i < 7; i++) begin
            rd_chk(8'(4 * i), 32'h0);
            wr(8'(4 * i), 32'h0000_2000 + i);
        end
        wr(crf_pkg::OFF_FLAGS, 32'h0);
        for (int i = 0; i < 7; i++) rd_chk(8'(4 * i), 32'h1000 + i);
        wr(crf_pkg::OFF_FLAGS, 32'h0000_0010);
        for (int i = 0; i < 7; i++) rd_chk(8'(4 * i), 32'h2000 + i);
        wr(crf_pkg::OFF_FLAGS, 32'h0);
        $display("test banks done");

        for (int i = 0; i < 5; i++) begin
            wr(U_OFF[i], 32'ha5c3_e871 + i);
            rd_chk(U_OFF[i], (32'ha5c3_e871 + i) & U_MSK[i]);
        end
        check("vector base", 32'(vector_base_q), 32'h0003_e871);
        check("instr ptr", 32'(instr_ptr_q), 32'h0003_e872);
        check("static base", 32'(static_base_q), 32'h0000_e875);
        wr(crf_pkg::OFF_FLAGS, 32'hffff_ff00);
        rd_chk(crf_pkg::OFF_FLAGS, 32'h0000_0700);
        wr(crf_pkg::OFF_FLAGS, 32'h0);
        rd_chk(8'h54, 32'h0);
        wr(8'hfc, 32'h1234_5678);
        rd_chk(8'hfc, 32'h0);
        @(posedge ref_clk);
        #1;
        check("idle read data", reg_rdata_q, 32'h0);
        $display("test words done");

        wr(8'h00, 32'h0000_1234);
        wr(crf_pkg::OFF_D0_HIGH, 32'hffff_ffab);
        rd_chk(8'h00, 32'h0000_ab34);
        wr(crf_pkg::OFF_D0_LOW, 32'h0000_00cd);
        rd_chk(8'h00, 32'h0000_abcd);
        rd_chk(crf_pkg::OFF_D0_HIGH, 32'h0000_00ab);
        wr(8'h04, 32'h0000_5566);
        rd_chk(crf_pkg::OFF_D1_HIGH, 32'h0000_0055);
        rd_chk(crf_pkg::OFF_D1_LOW, 32'h0000_0066);
        wr(crf_pkg::OFF_PAIR_LO, 32'h1111_2222);
        rd_chk(8'h00, 32'h0000_2222);
        rd_chk(8'h08, 32'h0000_1111);
        wr(crf_pkg::OFF_PAIR_HI, 32'h3333_4444);
        rd_chk(8'h04, 32'h0000_4444);
        rd_chk(8'h0c, 32'h0000_3333);
        rd_chk(crf_pkg::OFF_PAIR_HI, 32'h3333_4444);
        wr(crf_pkg::OFF_ADDR_LONG, 32'h7777_8888);
        rd_chk(8'h10, 32'h0000_8888);
        rd_chk(8'h14, 32'h0000_7777);
        $display("test halves and pairs done");

        wr(crf_pkg::OFF_USER_SP, 32'h0000_0a0a);
        wr(crf_pkg::OFF_INTR_SP, 32'h0000_0b0b);
        rd_chk(crf_pkg::OFF_ACTIVE_SP, 32'h0000_0a0a);
        wr(crf_pkg::OFF_FLAGS, 32'h0000_0080);
        rd_chk(crf_pkg::OFF_ACTIVE_SP, 32'h0000_0b0b);
        // Alias writes land in the selected pointer only
        wr(crf_pkg::OFF_ACTIVE_SP, 32'h0000_0c0c);
        rd_chk(crf_pkg::OFF_INTR_SP, 32'h0000_0c0c);
        rd_chk(crf_pkg::OFF_USER_SP, 32'h0000_0a0a);
        wr(crf_pkg::OFF_FLAGS, 32'h0);
        wr(crf_pkg::OFF_ACTIVE_SP, 32'h0000_0d0d);
        rd_chk(crf_pkg::OFF_USER_SP, 32'h0000_0d0d);
        rd_chk(crf_pkg::OFF_INTR_SP, 32'h0000_0c0c);
        $display("test stacks done");

        alu(1'b0, 32'h0000_0000, 1'b1, 1'b0);
        alu(1'b0, 32'h0001_8000, 1'b0, 1'b1);
        alu(1'b0, 32'h0001_0000, 1'b1, 1'b0);
        alu(1'b1, 32'h0001_0000, 1'b0, 1'b0);
        alu(1'b1, 32'h8000_0000, 1'b1, 1'b1);
        alu(1'b1, 32'h0000_0000, 1'b0, 1'b0);
        $display("test alu flags done");

        // Request held while masked, then enabled: exactly one acceptance
        @(posedge ref_clk);
        irq_req <= 1'b1;
        repeat (3) begin
            @(posedge ref_clk);
            #1;
            check("masked accept", 32'(irq_accept_q), 32'h0);
        end
        wr(crf_pkg::OFF_FLAGS, 32'h0000_0040);
        @(posedge ref_clk);
        #1;
        check("accept pulse", 32'(irq_accept_q), 32'h1);
        check("enable cleared", 32'(flags_q[crf_pkg::FLG_I]), 32'h0);
        @(posedge ref_clk);
        #1;
        check("accept ends", 32'(irq_accept_q), 32'h0);
        @(posedge ref_clk);
        irq_req <= 1'b0;
        $display("test interrupt done");
        stop_test();
    end
endmodule
